//--- verilog/fault_status_flags.v
// General fault and status flag bank of the LED bypass matrix, with the
// address-resistor measurement status, fault pin and interrupt.
// Assumes per-LED status bits and switch commands come from logic on
// i_clock; comparator levels come from the analog side and are synced.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "fault_status_regs.vh"

module fault_status_flags (
    // Clock and reset
    input wire i_clock,
    input wire i_rstn,

    // Register port
    input wire [7:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,

    // Per-LED status from the LED monitors
    input wire [5:0] i_per_led_unlit,
    input wire [5:0] i_per_led_bridged,
    input wire [5:0] i_per_led_break,

    // Analog comparator levels
    input wire i_pump_not_ok,
    input wire i_overheat_warn,
    input wire i_overheat_shdn,

    // Resistor converter
    output wire o_adc_start,
    output wire [1:0] o_adc_chan,
    input wire i_adc_done,
    input wire [5:0] i_adc_raw,

    // Bypass switches
    input wire [5:0] i_switch_cmd,
    output reg [5:0] o_switch_drive,

    // Fault pin and interrupt
    output reg o_fault_out_n,
    output reg o_irq
);

    // Sticky flag update where a set in the clear cycle wins
    function sticky;
        input cur;
        input set;
        input clr;
        begin
            sticky = set | (cur & ~clr);
        end
    endfunction

    // Synchronisers for the analog levels
    reg [2:0] sync1_reg;
    reg [2:0] sync2_reg;

    // Latched thermal flags
    reg overheat_warning_flag_reg;
    reg overheat_shutdown_flag_reg;

    // Software registers
    reg [5:0] general_mask_reg;
    reg [3:0] irq_mask_reg;
    reg [3:0] irq_status_reg;
    reg [5:0] overheat_switch_action_reg;

    // Edge history for interrupt events
    reg pump_prev_reg;
    reg warn_prev_reg;
    reg shdn_prev_reg;
    reg done_prev_reg;

    // Summary and decode wires
    wire unlit_led_summary;
    wire bridged_led_summary;
    wire break_summary;
    wire pump_not_ok;
    wire warn_level;
    wire shdn_level;
    wire [5:0] general_status;
    wire [12:0] resistor_measure_status;
    wire [12:0] resistor_codes;
    wire gen_write;
    wire irq_status_read;
    wire [3:0] irq_events;

    // Measurement results
    wire [11:0] res_codes;
    wire [2:0] res_too_high;
    wire [2:0] res_too_low;
    wire res_done;

    // Power-up resistor measurement
    addr_res_meas u_meas (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .o_adc_start(o_adc_start),
        .o_adc_chan(o_adc_chan),
        .i_adc_done(i_adc_done),
        .i_adc_raw(i_adc_raw),
        .o_codes(res_codes),
        .o_too_high(res_too_high),
        .o_too_low(res_too_low),
        .o_done(res_done)
    );

    // Two flops on each comparator; only the second stage is read
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
        end else begin
            sync1_reg <= {i_overheat_shdn, i_overheat_warn, i_pump_not_ok};
            sync2_reg <= sync1_reg;
        end
    end

    assign pump_not_ok = sync2_reg[0];
    assign warn_level = sync2_reg[1];
    assign shdn_level = sync2_reg[2];

    // Summaries follow the per-LED bits with no latching
    assign break_summary = |i_per_led_break;
    assign unlit_led_summary = |i_per_led_unlit;
    assign bridged_led_summary = |i_per_led_bridged;

    // General status image
    assign general_status[`GEN_BREAK_BIT] = break_summary;
    assign general_status[`GEN_UNLIT_BIT] = unlit_led_summary;
    assign general_status[`GEN_BRIDGED_BIT] = bridged_led_summary;
    assign general_status[`GEN_PUMP_BIT] = pump_not_ok;
    assign general_status[`GEN_SHDN_BIT] = overheat_shutdown_flag_reg;
    assign general_status[`GEN_WARN_BIT] = overheat_warning_flag_reg;

    // Resistor status: done, three over flags, three under flags
    assign resistor_measure_status = {
        6'h00,
        res_done,
        res_too_high,
        res_too_low
    };

    // Codes show each channel as soon as it is measured, not held at zero until done
    assign resistor_codes = {1'b0, res_codes};

    // Register port decode
    assign gen_write = i_wr && (i_addr == `OFS_GENERAL_STATUS);
    assign irq_status_read = i_rd && (i_addr == `OFS_IRQ_STATUS);

    // Thermal flags latch while the comparator is high; a write of 1
    // clears them, but a still-hot part sets them again at once
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            overheat_warning_flag_reg <= 1'b0;
            overheat_shutdown_flag_reg <= 1'b0;
        end else begin
            overheat_warning_flag_reg <= sticky(
                overheat_warning_flag_reg, warn_level,
                gen_write & i_wdata[`GEN_WARN_BIT]);
            overheat_shutdown_flag_reg <= sticky(
                overheat_shutdown_flag_reg, shdn_level,
                gen_write & i_wdata[`GEN_SHDN_BIT]);
        end
    end

    // Software-written configuration
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            general_mask_reg <= `RST_GENERAL_MASK;
            irq_mask_reg <= `RST_IRQ_MASK;
            overheat_switch_action_reg <= `RST_SHDN_ACTION;
        end else if (i_wr) begin
            if (i_addr == `OFS_GENERAL_MASK) begin
                general_mask_reg <= i_wdata[5:0];
            end else if (i_addr == `OFS_IRQ_MASK) begin
                irq_mask_reg <= i_wdata[3:0];
            end else if (i_addr == `OFS_SHDN_ACTION) begin
                overheat_switch_action_reg <= i_wdata[5:0];
            end
        end
    end

    // Rising edges of the watched conditions become interrupt events
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            pump_prev_reg <= 1'b0;
            warn_prev_reg <= 1'b0;
            shdn_prev_reg <= 1'b0;
            done_prev_reg <= 1'b0;
        end else begin
            pump_prev_reg <= pump_not_ok;
            warn_prev_reg <= overheat_warning_flag_reg;
            shdn_prev_reg <= overheat_shutdown_flag_reg;
            done_prev_reg <= res_done;
        end
    end

    assign irq_events[`IRQ_WARN_BIT] =
        overheat_warning_flag_reg & ~warn_prev_reg;
    assign irq_events[`IRQ_SHDN_BIT] =
        overheat_shutdown_flag_reg & ~shdn_prev_reg;
    assign irq_events[`IRQ_PUMP_BIT] = pump_not_ok & ~pump_prev_reg;
    assign irq_events[`IRQ_MEAS_BIT] = res_done & ~done_prev_reg;

    // Interrupt status is cleared by reading it; an event in the read
    // cycle stays set so that it is seen on the next read
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_status_reg <= 4'h0;
        end else begin
            irq_status_reg <= irq_events |
                (irq_status_reg & {4{~irq_status_read}});
        end
    end

    // Read data stand in the cycle after the strobe only
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (!i_rd) begin
            o_rdata <= 16'h0000;
        end else if (i_addr == `OFS_GENERAL_STATUS) begin
            o_rdata <= {10'h000, general_status};
        end else if (i_addr == `OFS_RES_STATUS) begin
            o_rdata <= {3'h0, resistor_measure_status};
        end else if (i_addr == `OFS_RES_CODES) begin
            o_rdata <= {3'h0, resistor_codes};
        end else if (i_addr == `OFS_GENERAL_MASK) begin
            o_rdata <= {10'h000, general_mask_reg};
        end else if (i_addr == `OFS_IRQ_STATUS) begin
            o_rdata <= {12'h000, irq_status_reg};
        end else if (i_addr == `OFS_IRQ_MASK) begin
            o_rdata <= {12'h000, irq_mask_reg};
        end else if (i_addr == `OFS_SHDN_ACTION) begin
            o_rdata <= {10'h000, overheat_switch_action_reg};
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // Switch drive: shutdown overrides the normal command so the LEDs
    // are put in a known state even if the host keeps writing
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_switch_drive <= 6'h00;
        end else if (overheat_shutdown_flag_reg) begin
            o_switch_drive <= overheat_switch_action_reg;
        end else begin
            o_switch_drive <= i_switch_cmd;
        end
    end

    // Fault pin and interrupt, registered to keep glitches off the pins
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            o_fault_out_n <= 1'b1;
            o_irq <= 1'b0;
        end else begin
            o_fault_out_n <=
                ~|(general_status & ~general_mask_reg);
            o_irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule

//--- verilog/fault_status_regs.vh
// Register offsets, field positions, reset values and converter limits for
// the fault and status flag bank. Definitions only; included by name.
//
// Contract
// - Bit 5 of the general status is high exactly while any per-LED wiring-break bit is high.
// - Bit 4 of the general status is high exactly while any per-LED unlit bit is high.
// - Bit 3 of the general status is high exactly while any per-LED bridged bit is high.
// - Read-only bit 2 shows the charge pump sitting below its good threshold.
// - Bit 1 latches an over-temperature shutdown until software writes 1 to it.
// - While the shutdown flag is set the switches follow the shutdown action, not normal commands.
// - Bit 0 latches an over-temperature warning until software writes 1 to it.
// - Bits 5, 4 and 3 of the resistor status flag resistors 2, 1 and 0 reading above the top code.
// - Bits 2, 1 and 0 of the resistor status flag resistors 2, 1 and 0 reading below the bottom code.
// - The active-low fault output is low while any unmasked general status bit is high.
// - The three address resistors are measured after power-up and a 4-bit code is kept for each.
`ifndef FAULT_STATUS_REGS_VH
`define FAULT_STATUS_REGS_VH

// Register offsets (byte address on the register port)
`define OFS_GENERAL_STATUS 8'h0a
`define OFS_RES_STATUS 8'h0b
`define OFS_RES_CODES 8'h0c
`define OFS_GENERAL_MASK 8'h10
`define OFS_IRQ_STATUS 8'h11
`define OFS_IRQ_MASK 8'h12
`define OFS_SHDN_ACTION 8'h13

// General status fields
`define GEN_BREAK_BIT 5
`define GEN_UNLIT_BIT 4
`define GEN_BRIDGED_BIT 3
`define GEN_PUMP_BIT 2
`define GEN_SHDN_BIT 1
`define GEN_WARN_BIT 0

// Resistor status fields
`define RES_DONE_BIT 6
`define RES_OVER_LSB 3
`define RES_UNDER_LSB 0

// Interrupt status fields
`define IRQ_WARN_BIT 0
`define IRQ_SHDN_BIT 1
`define IRQ_PUMP_BIT 2
`define IRQ_MEAS_BIT 3

// Reset values
`define RST_GENERAL_MASK 6'h00
`define RST_IRQ_MASK 4'h0
`define RST_SHDN_ACTION 6'h3f

// Raw converter window that maps onto the 4-bit code
`define RES_RAW_MIN 6'h08
`define RES_RAW_MAX 6'h17
`define RES_CHANNELS 2'h3

`endif

//--- verilog/addr_res_meas.v
// Power-up measurement sequencer for the three address resistors.
// Assumes an on-chip converter on the same clock that answers each
// start pulse with one done pulse and a 6-bit raw reading.
`timescale 1ns/1ps
`include "fault_status_regs.vh"

module addr_res_meas (
    // Clock and reset
    input wire i_clock,
    input wire i_rstn,
    // Converter handshake
    output wire o_adc_start,
    output reg [1:0] o_adc_chan,
    input wire i_adc_done,
    input wire [5:0] i_adc_raw,
    // Results
    output reg [11:0] o_codes,
    output reg [2:0] o_too_high,
    output reg [2:0] o_too_low,
    output reg o_done
);

    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_DONE = 3'h4;

    reg [2:0] state_reg;
    wire [5:0] offset;
    reg [3:0] code;

    // Clamp the raw reading into the code range
    assign offset = i_adc_raw - `RES_RAW_MIN;
    always @* begin
        if (i_adc_raw < `RES_RAW_MIN) begin
            code = 4'h0;
        end else if (i_adc_raw > `RES_RAW_MAX) begin
            code = 4'hf;
        end else begin
            code = offset[3:0];
        end
    end

    assign o_adc_start = (state_reg == ST_START);

    // One pass over the channels, then park until the next reset
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= ST_START;
            o_adc_chan <= 2'h0;
            o_codes <= 12'h000;
            o_too_high <= 3'h0;
            o_too_low <= 3'h0;
            o_done <= 1'b0;
        end else begin
            case (state_reg)
                ST_START: begin
                    state_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (i_adc_done) begin
                        o_codes[o_adc_chan*4 +: 4] <= code;
                        o_too_high[o_adc_chan] <=
                            (i_adc_raw > `RES_RAW_MAX);
                        o_too_low[o_adc_chan] <=
                            (i_adc_raw < `RES_RAW_MIN);
                        if (o_adc_chan == `RES_CHANNELS - 2'h1) begin
                            state_reg <= ST_DONE;
                            o_done <= 1'b1;
                        end else begin
                            o_adc_chan <= o_adc_chan + 2'h1;
                            state_reg <= ST_START;
                        end
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_DONE;
                end
                default: begin
                    state_reg <= ST_START;
                end
            endcase
        end
    end

endmodule

//--- tb/fsf_checker.sv
// Port assertions for the fault and status flag bank.
// Assumes one clock domain and the register map header on the path.
`timescale 1ns/1ps
`include "fault_status_regs.vh"
module fsf_checker (
    // Clock, reset and register port
    input wire logic i_clock, i_rstn, i_wr, i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [15:0] o_rdata,
    // Status sources
    input wire logic [5:0] i_per_led_unlit, i_per_led_bridged,
    input wire logic [5:0] i_per_led_break,
    input wire logic i_pump_not_ok, i_overheat_warn, i_overheat_shdn,
    // Converter and fault pin
    input wire logic o_adc_start, i_adc_done, o_fault_out_n,
    input wire logic [1:0] o_adc_chan
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    logic [5:0] msk;
    logic [2:0] up;
    // Mask copy; settle count keeps synced comparators out of reset edges
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            msk <= 6'h00;
            up <= 3'h0;
        end else begin
            if (i_wr && i_addr == `OFS_GENERAL_MASK) msk <= i_wdata[5:0];
            if (up != 3'h7) up <= up + 3'h1;
        end
    end
    sequence rd_gen;
        i_rd && i_addr == `OFS_GENERAL_STATUS;
    endsequence
    sequence rd_res;
        i_rd && i_addr == `OFS_RES_STATUS;
    endsequence
    a_break_any: assert property (rd_gen |=>
        o_rdata[5] == |$past(i_per_led_break)) else $error("break summary");
    a_unlit_any: assert property (rd_gen |=>
        o_rdata[4] == |$past(i_per_led_unlit)) else $error("unlit summary");
    a_bridged_any: assert property (rd_gen |=>
        o_rdata[3] == |$past(i_per_led_bridged)) else $error("bridged sum");
    a_pump_level: assert property (
        ($stable(i_pump_not_ok))[*5] ##0 rd_gen ##0 up == 3'h7 |=>
        o_rdata[2] == $past(i_pump_not_ok)) else $error("pump flag");
    a_shdn_latch: assert property (
        (i_overheat_shdn)[*5] ##0 rd_gen ##0 up == 3'h7 |=> o_rdata[1])
        else $error("shutdown flag not set");
    a_warn_latch: assert property (
        (i_overheat_warn)[*5] ##0 rd_gen ##0 up == 3'h7 |=> o_rdata[0])
        else $error("warning flag not set");
    // Read data stand for one cycle only; any other cycle shows zero
    a_rdata_idle: assert property (!i_rd |=>
        o_rdata == 16'h0000) else $error("read data outside read slot");
    a_res_range: assert property (rd_res |=>
        (o_rdata[5:3] & o_rdata[2:0]) == 3'h0) else $error("range flags");
    a_chan_hold: assert property (!$stable(o_adc_chan) |->
        $past(i_adc_done)) else $error("channel moved while waiting");
    a_next_start: assert property (i_adc_done && o_adc_chan != 2'h2 |=>
        o_adc_start) else $error("no start after done");
    a_fault_low: assert property (|i_per_led_unlit && !msk[4] |=>
        !o_fault_out_n) else $error("fault pin not asserted");
endmodule
bind fault_status_flags fsf_checker u_fsf_checker (.i_clock(i_clock),
    .i_rstn(i_rstn), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_per_led_unlit(i_per_led_unlit),
    .i_per_led_bridged(i_per_led_bridged), .i_per_led_break(i_per_led_break),
    .i_pump_not_ok(i_pump_not_ok), .i_overheat_warn(i_overheat_warn),
    .i_overheat_shdn(i_overheat_shdn), .o_adc_start(o_adc_start),
    .i_adc_done(i_adc_done), .o_fault_out_n(o_fault_out_n),
    .o_adc_chan(o_adc_chan));

//--- tb/adc_model.sv
// Behavioural resistor converter: answers each start with one done pulse.
// Latency grows with channel so both prompt and slow answers occur.
`timescale 1ns/1ps
module adc_model (
    input wire logic i_clock, i_rstn, i_start,
    input wire logic [1:0] i_chan,
    input wire logic [17:0] i_raws,
    output logic o_done,
    output logic [5:0] o_raw
);
    logic busy;
    logic [2:0] cnt;
    // Reading is only valid with done; otherwise it toggles every cycle
    always @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            busy <= 1'b0;
            cnt <= 3'h0;
            o_done <= 1'b0;
            o_raw <= 6'h2a;
        end else begin
            o_done <= 1'b0;
            o_raw <= ~o_raw;
            if (i_start && !busy) begin
                busy <= 1'b1;
                cnt <= {i_chan, 1'b0};
            end else if (busy && cnt == 3'h0) begin
                busy <= 1'b0;
                o_done <= 1'b1;
                o_raw <= i_raws[i_chan*6+:6];
            end else if (busy) begin
                cnt <= cnt - 3'h1;
            end
        end
    end
endmodule

//--- tb/fault_status_flags_tb.sv
// Self-checking bench for the flag bank with a converter model.
// Assumes the register map header on the include path.
`timescale 1ns/1ps
`include "fault_status_regs.vh"
module fault_status_flags_tb;
    logic i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0, pump = 0;
    logic warn = 0, shdn = 0, done, start, fault_n, irq;
    logic [7:0] i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata, d = 16'h0000;
    logic [5:0] unlit = 0, brg = 0, brk = 0, cmd = 0, raw, drive;
    logic [1:0] chan;
    // Resistor 2 in window, 1 above it, 0 below it
    logic [17:0] raws = {6'h10, 6'h30, 6'h05};
    integer seed = 32'h85d7, n_errors = 0, num_checks = 0, k;
    always #5 i_clock = ~i_clock;
    adc_model u_adc_model (.i_clock(i_clock), .i_rstn(i_rstn),
        .i_start(start),
        .i_chan(chan), .i_raws(raws), .o_done(done), .o_raw(raw));
    fault_status_flags u_fault_status_flags (.i_clock(i_clock),
        .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_per_led_unlit(unlit),
        .i_per_led_bridged(brg), .i_per_led_break(brk),
        .i_pump_not_ok(pump), .i_overheat_warn(warn),
        .i_overheat_shdn(shdn), .o_adc_start(start), .o_adc_chan(chan),
        .i_adc_done(done), .i_adc_raw(raw), .i_switch_cmd(cmd),
        .o_switch_drive(drive), .o_fault_out_n(fault_n), .o_irq(irq));
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle(input integer n);
        repeat (n) @(posedge i_clock);
    endtask
    // One-cycle strobes; data lands in the cycle after a read
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    function automatic logic [15:0] res_exp(input logic [17:0] r);
        res_exp = 16'h0040;
        for (int j = 0; j < 3; j++) begin
            if (r[j*6+:6] > 6'h17) res_exp[3+j] = 1'b1;
            if (r[j*6+:6] < 6'h08) res_exp[j] = 1'b1;
        end
    endfunction
    function automatic logic [15:0] code_exp(input logic [17:0] r);
        logic [5:0] v;
        code_exp = 16'h0000;
        for (int j = 0; j < 3; j++) begin
            v = r[j*6+:6];
            code_exp[j*4+:4] = v < 6'h08 ? 4'h0 : v > 6'h17 ? 4'hf :
                4'(v - 6'h08);
        end
    endfunction
    function automatic logic [15:0] gen_exp();
        return {10'h000, |brk, |unlit, |brg, pump, 2'b00};
    endfunction
    initial begin
        idle(16);
        i_rstn <= 1'b1;
        // Poll the done flag under a bound
        for (k = 0; k < 200 && d[6] !== 1'b1; k++) rd(`OFS_RES_STATUS);
        if (d[6] !== 1'b1) begin
            n_errors++;
            final_report;
        end
        chk(d, res_exp(raws));
        rd(`OFS_RES_CODES);
        chk(d, code_exp(raws));
        rd(8'h3f);
        chk(d, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        // Random levels; first pass all quiet
        for (k = 0; k < 30; k++) begin
            @(posedge i_clock);
            unlit <= k == 0 ? 6'h00 : 6'($random(seed) & $random(seed));
            brg <= k == 0 ? 6'h00 : 6'($random(seed) & $random(seed));
            brk <= k == 0 ? 6'h00 : 6'($random(seed) & $random(seed));
            pump <= k == 0 ? 1'b0 : 1'($random(seed));
            cmd <= 6'($random(seed));
            idle(5);
            rd(`OFS_GENERAL_STATUS);
            chk(d, gen_exp());
            chk({15'h0, fault_n}, {15'h0, ~|gen_exp()});
            chk({10'h0, drive}, {10'h0, cmd});
        end
        @(posedge i_clock);
        {unlit, brg, brk, pump} <= {6'h01, 6'h00, 6'h00, 1'b0};
        wr(`OFS_GENERAL_MASK, 16'h0010);
        idle(3);
        chk({15'h0, fault_n}, 16'h0001);
        wr(`OFS_GENERAL_MASK, 16'h0000);
        idle(2);
        chk({15'h0, fault_n}, 16'h0000);
        unlit <= 6'h00;
        rd(`OFS_IRQ_STATUS);
        wr(`OFS_IRQ_MASK, 16'h0003);
        wr(`OFS_SHDN_ACTION, 16'h0015);
        // Heat event, then cool down; flags must stay latched
        @(posedge i_clock);
        {cmd, warn, shdn} <= {6'h2a, 1'b1, 1'b1};
        idle(5);
        rd(`OFS_GENERAL_STATUS);
        chk(d, 16'h0003);
        @(posedge i_clock);
        {warn, shdn} <= 2'b00;
        idle(5);
        rd(`OFS_GENERAL_STATUS);
        chk(d, 16'h0003);
        chk({10'h0, drive}, 16'h0015);
        chk({15'h0, irq}, 16'h0001);
        wr(`OFS_GENERAL_STATUS, 16'h0003);
        idle(2);
        rd(`OFS_GENERAL_STATUS);
        chk(d, 16'h0000);
        chk({10'h0, drive}, 16'h002a);
        rd(`OFS_IRQ_STATUS);
        chk(d, 16'h0003);
        idle(2);
        chk({15'h0, irq}, 16'h0000);
        final_report;
    end
endmodule
